// ---- pkg/pcl_pkg.sv ----
// Constants, register map and state codes of the power-up config loader.
// Assumes a byte-wide internal register port behind the serial interface.
package pcl_pkg;
  localparam int          MIR_WORDS     = 3;
  localparam int          IDX_W         = 2;
  localparam logic [1:0]  IDX_LAST      = 2'h2;
  localparam logic [1:0]  IDX_FIRST     = 2'h0;
  // Register offsets
  localparam logic [7:0]  OFS_SERIAL    = 8'ha0;
  localparam logic [7:0]  OFS_CTRL_A    = 8'ha1;
  localparam logic [7:0]  OFS_CTRL_B    = 8'ha2;
  localparam logic [7:0]  OFS_PAGE_SEL  = 8'h77;
  localparam logic [7:0]  OFS_FAULTS    = 8'h7e;
  // Page select field
  localparam logic [2:0]  PAGE_BASE     = 3'h0;
  localparam logic [2:0]  PAGE_MIRROR   = 3'h1;
  localparam int          PAGE_W        = 3;
  // Fault register bit positions
  localparam int          FLT_TRIM      = 0;
  localparam int          FLT_FUSE      = 1;
  localparam int          FLT_STEST     = 2;
  // Write value that clears a fault flag, per source
  localparam logic        CLR_VAL_FUSE  = 1'b1;
  localparam logic        CLR_VAL_HW    = 1'b0;
  // Serial config field layout
  localparam int          SER_SECURE    = 7;
  localparam int          SER_CRC       = 6;
  localparam int          SER_ADDR_LSB  = 0;
  localparam int          SER_ADDR_MSB  = 2;
  localparam logic [6:0]  TRIAL_ADDR    = 7'h08;
  // Reset and image values
  localparam logic [7:0]  MIR_RST       = 8'h00;
  localparam logic [7:0]  FUNC_RST      = 8'h00;
  localparam logic [7:0]  HW_IMAGE [MIR_WORDS] = '{8'h00, 8'h02, 8'h05};

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FREQ  = 5'h02,
    ST_FWAIT = 5'h04,
    ST_XFER  = 5'h08,
    ST_HWLD  = 5'h10
  } pcl_state_type;
endpackage

// ---- pkg/pcl_mir_if.sv ----
// Mirror bank access between the loader control and the bank.
// Assumes a single clock shared by both ends.
interface pcl_mir_if;
  logic                        fuse_we;
  logic [pcl_pkg::IDX_W-1:0]   fuse_idx;
  logic [7:0]                  fuse_data;
  logic                        host_we;
  logic [pcl_pkg::IDX_W-1:0]   host_idx;
  logic [7:0]                  host_data;
  logic                        wipe;
  logic [7:0]                  words [pcl_pkg::MIR_WORDS];

  modport ctl  (output fuse_we, fuse_idx, fuse_data, host_we, host_idx,
                host_data, wipe, input words);
  modport bank (input fuse_we, fuse_idx, fuse_data, host_we, host_idx,
                host_data, wipe, output words);
endinterface

// ---- rtl/pcl_mirror_bank.sv ----
// Fuse mirror registers, filled from fuses and rewritable by the host.
// Assumes the controller never raises fuse and host writes together.
module pcl_mirror_bank (
  input  wire logic clk,      // Clock
  input  wire logic arst_n,   // Async reset, active low
  input  wire logic clk_en,   // Clock enable
  pcl_mir_if.bank   mir       // Mirror access
);
  logic [7:0] mem_ff [pcl_pkg::MIR_WORDS];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < pcl_pkg::MIR_WORDS; i++) begin
        mem_ff[i] <= pcl_pkg::MIR_RST;
      end
    end else if (clk_en) begin
      if (mir.wipe) begin
        for (int i = 0; i < pcl_pkg::MIR_WORDS; i++) begin
          mem_ff[i] <= pcl_pkg::MIR_RST;
        end
      end else if (mir.fuse_we) begin
        mem_ff[mir.fuse_idx] <= mir.fuse_data;
      end else if (mir.host_we) begin
        mem_ff[mir.host_idx] <= mir.host_data;
      end
    end
  end

  assign mir.words = mem_ff;
endmodule

// ---- rtl/pcl_fault_flag.sv ----
// One sticky fault flag; a set in the clearing cycle wins.
// Assumes set, clear and force are synchronous one-cycle or level terms.
module pcl_fault_flag (
  input  wire logic clk,      // Clock
  input  wire logic arst_n,   // Async reset, active low
  input  wire logic clk_en,   // Clock enable
  input  wire logic set,      // Fault seen
  input  wire logic clr,      // Software clear
  input  wire logic force_lo, // Hold at zero
  output logic      flag      // Flag state
);
  logic flag_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (force_lo) begin
        flag_ff <= 1'b0;
      end else if (set) begin
        flag_ff <= 1'b1;
      end else if (clr) begin
        flag_ff <= 1'b0;
      end
    end
  end

  assign flag = flag_ff;
endmodule

// ---- rtl/pcl_loader.sv ----
// Power-up configuration loader: fuse or hardwire source, trial mode.
// Assumes synchronous inputs and a register port from the serial slave.
// Operation
// - Grounded source strap loads mirror; rail strap loads hardwire image.
// - Fuse source copies fuses into mirror on every supply rise.
// - After fuse copy, mirror contents move into functional registers.
// - Hardwire source reloads functional registers directly; no trial mode.
// - Fuse source faults block power-up until cleared by writing 1 in off.
// - Fault flags writable only with trial strap high, else read-only.
// - Trial strap forces quiescent off, ignoring low-power-off default.
// - Self-test fault flag shows the real self-test result.
// - Trial mode: no CRC, no secure write, address 0x08.
// - Trial mode disables external watchdog input and watchdog timer.
// - Mirror on page 1 in trial mode; extended pages refused otherwise.
// - Mirror preloaded from fuses, host may rewrite it in trial mode.
// - Power-up with trial strap high gives restricted functions.
// - Supply falling below threshold resets the mirror registers.
// - Fuse burning only in trial mode and quiescent off state.
// - Hardwire source still reads trim; trim failure sets trim flag.
// - Hardwire source with trial strap gives debug mode, same off entry.
// - Hardwire source keeps fuse-load fault flag cleared.
// - Hardwire faults block power-up until cleared by writing 0.
module pcl_loader (
  input  wire logic       clk,                // Clock, 250 MHz
  input  wire logic       arst_n,             // Async reset, active low
  input  wire logic       clk_en,             // Clock enable
  input  wire logic       config_source_strap, // High: hardwire image
  input  wire logic       trial_mode_strap,   // High: trial or debug
  input  wire logic       supply_above_uv,    // Supply above threshold
  input  wire logic       power_up_event,     // Power-up request pulse
  input  wire logic       in_quiescent_off,   // Sequencer in off state
  input  wire logic       low_power_off_default, // Stored off default
  input  wire logic       trim_fail,          // Trim load failed pulse
  input  wire logic       self_test_done,     // Self-test result valid
  input  wire logic       self_test_fail,     // Self-test failed
  input  wire logic       burn_req,           // Host fuse burn request
  output logic            fuse_rd_req,        // Fuse word read request
  output logic [1:0]      fuse_rd_idx,        // Fuse word index
  input  wire logic       fuse_rd_valid,      // Fuse word returned
  input  wire logic [7:0] fuse_rd_data,       // Fuse word data
  input  wire logic       fuse_rd_err,        // Fuse word read failed
  output logic            fuse_burn_en,       // Fuse burn permitted
  input  wire logic       reg_wr,             // Register write strobe
  input  wire logic       reg_rd,             // Register read strobe
  input  wire logic [7:0] reg_addr,           // Register offset
  input  wire logic [7:0] reg_wdata,          // Register write data
  output logic [7:0]      reg_rdata,          // Register read data
  output logic            reg_ack,            // Access done pulse
  output logic            reg_err,            // Access refused pulse
  output logic [7:0]      func_serial,        // Functional serial config
  output logic [7:0]      func_ctrl_a,        // Functional control A
  output logic [7:0]      func_ctrl_b,        // Functional control B
  output logic            load_done,          // Default load complete
  output logic            power_up_go,        // Accepted power-up pulse
  output logic            enter_quiescent_off, // Go to off after test
  output logic            restricted,         // Restricted functions
  output logic            crc_en,             // Serial CRC enable
  output logic            secure_wr_en,       // Secure write enable
  output logic [6:0]      target_addr,        // Serial target address
  output logic            watchdog_disable    // Watchdog supervision off
);
  pcl_mir_if mir ();

  pcl_pkg::pcl_state_type state_ff;
  pcl_pkg::pcl_state_type nxt_state;
  logic [1:0]             idx_ff;
  logic                   supply_prev_ff;
  logic                   src_hw_ff;
  logic [2:0]             page_ff;
  logic                   restricted_ff;
  logic                   fuse_rd_req_ff;
  logic                   fuse_burn_en_ff;
  logic [7:0]             reg_rdata_ff;
  logic                   reg_ack_ff;
  logic                   reg_err_ff;
  logic [7:0]             func_ff [pcl_pkg::MIR_WORDS];
  logic                   load_done_ff;
  logic                   power_up_go_ff;
  logic                   quiet_off_ff;
  logic                   crc_en_ff;
  logic                   secure_wr_en_ff;
  logic [6:0]             target_addr_ff;
  logic                   wd_dis_ff;
  logic                   fuse_err_seen;

  logic supply_rise;
  logic supply_fall;
  logic trial_mode;
  logic any_fault;
  logic acc;
  logic ext_page;
  logic hit_page;
  logic hit_fault;
  logic hit_mirror;
  logic hit_func;
  logic refused;
  logic clr_val;
  logic flt_wr_ok;
  logic [2:0] flt_clr;
  logic [2:0] flt_set;
  logic [2:0] flags;
  logic [1:0] acc_idx;
  logic       limit_now;
  logic [7:0] ser_src;

  assign supply_rise = supply_above_uv && !supply_prev_ff;
  assign supply_fall = !supply_above_uv && supply_prev_ff;
  // no trial mode on hardwire source
  assign trial_mode  = trial_mode_strap && !src_hw_ff;
  assign any_fault   = |flags;
  assign acc         = reg_wr || reg_rd;
  assign ext_page    = page_ff != pcl_pkg::PAGE_BASE;
  assign acc_idx     = reg_addr[1:0];
  assign hit_page    = reg_addr == pcl_pkg::OFS_PAGE_SEL;
  assign hit_fault   = !ext_page && reg_addr == pcl_pkg::OFS_FAULTS;
  assign hit_func    = !ext_page && reg_addr >= pcl_pkg::OFS_SERIAL &&
                       reg_addr <= pcl_pkg::OFS_CTRL_B;
  // mirror window on page 1, trial only
  assign hit_mirror  = trial_mode && page_ff == pcl_pkg::PAGE_MIRROR &&
                       reg_addr >= pcl_pkg::OFS_SERIAL &&
                       reg_addr <= pcl_pkg::OFS_CTRL_B;
  assign refused     = !(hit_page || hit_fault || hit_func || hit_mirror) ||
                       (reg_wr && hit_func) ||
                       (reg_wr && hit_fault && !trial_mode_strap);

  assign clr_val   = src_hw_ff ? pcl_pkg::CLR_VAL_HW : pcl_pkg::CLR_VAL_FUSE;
  // writes only with trial strap high
  // fuse source clears only in off state
  assign flt_wr_ok = clk_en && reg_wr && hit_fault && trial_mode_strap &&
                     (src_hw_ff || in_quiescent_off);
  assign flt_clr   = {3{flt_wr_ok}} & ~(reg_wdata[2:0] ^ {3{clr_val}});
  assign flt_set[pcl_pkg::FLT_TRIM]  = trim_fail;
  assign flt_set[pcl_pkg::FLT_FUSE]  = fuse_err_seen;
  assign flt_set[pcl_pkg::FLT_STEST] = self_test_done && self_test_fail;
  assign fuse_err_seen = state_ff == pcl_pkg::ST_FWAIT && fuse_rd_valid &&
                         fuse_rd_err;

  for (genvar g = 0; g < 3; g++) begin : g_flt
    logic force_lo;
    logic pass_clr;
    // fuse flag held clear on hardwire source
    assign force_lo = (g == pcl_pkg::FLT_FUSE) && src_hw_ff;
    assign pass_clr = (g == pcl_pkg::FLT_STEST) && self_test_done &&
                      !self_test_fail;
    pcl_fault_flag u_flag (
      .clk      (clk),
      .arst_n   (arst_n),
      .clk_en   (clk_en),
      .set      (flt_set[g]),
      .clr      (flt_clr[g] || pass_clr),
      .force_lo (force_lo),
      .flag     (flags[g])
    );
  end

  pcl_mirror_bank u_mirror (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .mir    (mir)
  );

  assign mir.fuse_we   = state_ff == pcl_pkg::ST_FWAIT && fuse_rd_valid &&
                         !fuse_rd_err;
  assign mir.fuse_idx  = idx_ff;
  assign mir.fuse_data = fuse_rd_data;
  assign mir.host_we   = clk_en && reg_wr && hit_mirror && !hit_page;
  assign mir.host_idx  = acc_idx;
  assign mir.host_data = reg_wdata;
  assign mir.wipe      = supply_fall;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pcl_pkg::ST_IDLE: begin
        if (supply_rise) begin
          nxt_state = config_source_strap ? pcl_pkg::ST_HWLD
                                          : pcl_pkg::ST_FREQ;
        end
      end
      pcl_pkg::ST_FREQ: begin
        nxt_state = pcl_pkg::ST_FWAIT;
      end
      pcl_pkg::ST_FWAIT: begin
        if (fuse_rd_valid) begin
          nxt_state = (idx_ff == pcl_pkg::IDX_LAST) ? pcl_pkg::ST_XFER
                                                    : pcl_pkg::ST_FREQ;
        end
      end
      pcl_pkg::ST_XFER: begin
        if (idx_ff == pcl_pkg::IDX_LAST) begin
          nxt_state = pcl_pkg::ST_IDLE;
        end
      end
      pcl_pkg::ST_HWLD: begin
        if (idx_ff == pcl_pkg::IDX_LAST) begin
          nxt_state = pcl_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = pcl_pkg::ST_IDLE;
      end
    endcase
    // Supply loss aborts any load
    if (supply_fall) begin
      nxt_state = pcl_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff       <= pcl_pkg::ST_IDLE;
      idx_ff         <= pcl_pkg::IDX_FIRST;
      supply_prev_ff <= 1'b0;
      src_hw_ff      <= 1'b0;
      fuse_rd_req_ff <= 1'b0;
      load_done_ff   <= 1'b0;
    end else if (clk_en) begin
      state_ff       <= nxt_state;
      supply_prev_ff <= supply_above_uv;
      fuse_rd_req_ff <= nxt_state == pcl_pkg::ST_FREQ;
      if (state_ff == pcl_pkg::ST_IDLE && supply_rise) begin
        src_hw_ff    <= config_source_strap;
        load_done_ff <= 1'b0;
        idx_ff       <= pcl_pkg::IDX_FIRST;
      end else if (state_ff == pcl_pkg::ST_FWAIT && fuse_rd_valid) begin
        idx_ff <= (idx_ff == pcl_pkg::IDX_LAST) ? pcl_pkg::IDX_FIRST
                                                : idx_ff + 2'h1;
      end else if (state_ff == pcl_pkg::ST_XFER ||
                   state_ff == pcl_pkg::ST_HWLD) begin
        idx_ff <= idx_ff + 2'h1;
        if (idx_ff == pcl_pkg::IDX_LAST) begin
          load_done_ff <= !supply_fall;
        end
      end
      if (supply_fall) begin
        load_done_ff <= 1'b0;
        idx_ff       <= pcl_pkg::IDX_FIRST;
      end
    end
  end

  // Functional registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < pcl_pkg::MIR_WORDS; i++) begin
        func_ff[i] <= pcl_pkg::FUNC_RST;
      end
    end else if (clk_en) begin
      if (state_ff == pcl_pkg::ST_XFER) begin
        func_ff[idx_ff] <= mir.words[idx_ff];
      end else if (state_ff == pcl_pkg::ST_HWLD) begin
        func_ff[idx_ff] <= pcl_pkg::HW_IMAGE[idx_ff];
      end
    end
  end

  // Register port answers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_ff      <= pcl_pkg::PAGE_BASE;
      reg_rdata_ff <= 8'h00;
      reg_ack_ff   <= 1'b0;
      reg_err_ff   <= 1'b0;
    end else if (clk_en) begin
      reg_ack_ff <= acc && !refused;
      reg_err_ff <= acc && refused;
      if (reg_wr && hit_page) begin
        page_ff <= reg_wdata[pcl_pkg::PAGE_W-1:0];
      end
      if (reg_rd && !refused) begin
        if (hit_page) begin
          reg_rdata_ff <= {5'h00, page_ff};
        end else if (hit_fault) begin
          reg_rdata_ff <= {5'h00, flags};
        end else if (hit_mirror) begin
          reg_rdata_ff <= mir.words[acc_idx];
        end else begin
          reg_rdata_ff <= func_ff[acc_idx];
        end
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

  assign limit_now = restricted_ff || trial_mode_strap;
  assign ser_src   = func_ff[0];

  // Power-up gating and mode outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      restricted_ff   <= 1'b0;
      power_up_go_ff  <= 1'b0;
      quiet_off_ff    <= 1'b0;
      crc_en_ff       <= 1'b0;
      secure_wr_en_ff <= 1'b0;
      target_addr_ff  <= pcl_pkg::TRIAL_ADDR;
      wd_dis_ff       <= 1'b1;
      fuse_burn_en_ff <= 1'b0;
    end else if (clk_en) begin
      power_up_go_ff <= power_up_event && load_done_ff && !any_fault;
      if (power_up_event && load_done_ff && !any_fault) begin
        restricted_ff <= trial_mode_strap;
      end
      quiet_off_ff    <= trial_mode_strap || low_power_off_default;
      crc_en_ff       <= !limit_now && ser_src[pcl_pkg::SER_CRC];
      secure_wr_en_ff <= !limit_now && ser_src[pcl_pkg::SER_SECURE];
      target_addr_ff  <= limit_now ? pcl_pkg::TRIAL_ADDR :
                         (pcl_pkg::TRIAL_ADDR |
                          {4'h0, ser_src[pcl_pkg::SER_ADDR_MSB:
                                         pcl_pkg::SER_ADDR_LSB]});
      wd_dis_ff       <= limit_now;
      // burn only in trial and off
      fuse_burn_en_ff <= burn_req && trial_mode && in_quiescent_off;
    end
  end

  assign fuse_rd_req         = fuse_rd_req_ff;
  assign fuse_rd_idx         = idx_ff;
  assign fuse_burn_en        = fuse_burn_en_ff;
  assign reg_rdata           = reg_rdata_ff;
  assign reg_ack             = reg_ack_ff;
  assign reg_err             = reg_err_ff;
  assign func_serial         = func_ff[0];
  assign func_ctrl_a         = func_ff[1];
  assign func_ctrl_b         = func_ff[2];
  assign load_done           = load_done_ff;
  assign power_up_go         = power_up_go_ff;
  assign enter_quiescent_off = quiet_off_ff;
  assign restricted          = restricted_ff;
  assign crc_en              = crc_en_ff;
  assign secure_wr_en        = secure_wr_en_ff;
  assign target_addr         = target_addr_ff;
  assign watchdog_disable    = wd_dis_ff;
endmodule

// ---- sim/pcl_fuse_model.sv ----
// Fuse bank model: answers each word read dly+1 cycles after the request.
// Assumes one read outstanding at a time.
module pcl_fuse_model (
  input  wire logic       clk,           // Clock
  input  wire logic       arst_n,        // Reset
  input  wire logic       fuse_rd_req,   // Read pulse
  input  wire logic [1:0] fuse_rd_idx,   // Word index
  input  wire logic [7:0] words [3],     // Contents
  input  wire logic [2:0] err_mask,      // Failing words
  input  wire logic [1:0] dly,           // Answer delay
  output logic            fuse_rd_valid, // Word valid
  output logic [7:0]      fuse_rd_data,  // Word data
  output logic            fuse_rd_err    // Word failed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt, cur;
  logic       pend;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {pend, fuse_rd_valid, fuse_rd_err, cnt, cur} <= '0;
      fuse_rd_data <= 8'h00;
    end else begin
      {fuse_rd_valid, fuse_rd_err} <= 2'b00;
      // Stale data toggles so it never looks valid
      fuse_rd_data <= ~fuse_rd_data;
      if (fuse_rd_req)
        {pend, cur, cnt} <= {1'b1, fuse_rd_idx, dly};
      else if (pend && cnt == 2'h0) begin
        {pend, fuse_rd_valid, fuse_rd_err} <= {2'b01, err_mask[cur]};
        fuse_rd_data <= words[cur];
      end else if (pend)
        cnt <= cnt - 2'h1;
    end
  end
endmodule

// ---- sim/pcl_loader_sva.sv ----
// Port checker for the power-up config loader.
// Bound into pcl_loader; watches its ports only.
module pcl_loader_sva (
  input wire logic       clk,                   // Clock
  input wire logic       arst_n,                // Async reset, active low
  input wire logic       clk_en,                // Clock enable
  input wire logic       trial_mode_strap,      // Trial strap
  input wire logic       supply_above_uv,       // Supply ok
  input wire logic       power_up_event,        // Power-up request
  input wire logic       power_up_go,           // Power-up accepted
  input wire logic       in_quiescent_off,      // Off state
  input wire logic       burn_req,              // Burn request
  input wire logic       low_power_off_default, // Off default
  input wire logic       reg_wr,                // Write strobe
  input wire logic       reg_rd,                // Read strobe
  input wire logic       reg_ack,               // Access done
  input wire logic       reg_err,               // Access refused
  input wire logic [7:0] func_serial,           // Serial config
  input wire logic       load_done,             // Load complete
  input wire logic       restricted,            // Restricted functions
  input wire logic       enter_quiescent_off,   // Off entry
  input wire logic       fuse_burn_en,          // Burn permitted
  input wire logic       crc_en,                // CRC enable
  input wire logic [6:0] target_addr,           // Serial address
  input wire logic       watchdog_disable       // Watchdog off
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  acc_answer_a: assert property (
    (reg_wr || reg_rd) && clk_en |=> reg_ack != reg_err)
    else $error("access not answered once");
  trial_limit_a: assert property (
    trial_mode_strap && clk_en |=> target_addr == 7'h08 && !crc_en
    && watchdog_disable) else $error("trial limits missing");
  restrict_addr_a: assert property (
    restricted && !power_up_event && clk_en |=> target_addr == 7'h08)
    else $error("restricted address wrong");
  normal_addr_a: assert property (
    !trial_mode_strap && !restricted && !power_up_event && load_done &&
    supply_above_uv && clk_en |=>
    target_addr == (7'h08 | {4'h0, $past(func_serial[2:0])}))
    else $error("address wrong");
  burn_gate_a: assert property (
    fuse_burn_en |-> $past(burn_req) && $past(trial_mode_strap) &&
    $past(in_quiescent_off))
    else $error("burn enabled outside trial off");
  go_cause_a: assert property (
    power_up_go |-> $past(power_up_event) && $past(load_done))
    else $error("power-up accepted without cause");
  uv_drop_a: assert property (
    !supply_above_uv && clk_en |=> !load_done) else $error("load kept");
  off_entry_a: assert property (
    clk_en |=> enter_quiescent_off ==
    ($past(trial_mode_strap) || $past(low_power_off_default)))
    else $error("off entry wrong");
  cover property (power_up_go);
  cover property ($rose(load_done));
  cover property (reg_err);
endmodule
bind pcl_loader pcl_loader_sva u_sva (.*);

// ---- sim/pcl_loader_tb.sv ----
// Self-checking bench for the power-up config loader.
// Fuse bank comes from pcl_fuse_model; one 250 MHz clock.
module pcl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, power_up_event = 1'b0;
  logic config_source_strap = 1'b0, trial_mode_strap = 1'b0;
  logic supply_above_uv = 1'b0, in_quiescent_off = 1'b0, trim_fail = 1'b0;
  logic low_power_off_default = 1'b0, burn_req = 1'b0, er;
  logic self_test_done = 1'b0, self_test_fail = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, fuse_rd_req, fuse_rd_valid;
  logic fuse_rd_err, fuse_burn_en, reg_ack, reg_err, load_done;
  logic power_up_go, enter_quiescent_off, restricted, crc_en;
  logic secure_wr_en, watchdog_disable;
  logic [1:0] fuse_rd_idx, dly = 2'h0;
  logic [2:0] err_mask = 3'h0;
  logic [6:0] target_addr;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd, v, fuse_rd_data;
  logic [7:0] reg_rdata, func_serial, func_ctrl_a, func_ctrl_b;
  logic [7:0] words [3], exp_fn [3];
  int err_total = 0, total_checks = 0, seed = 16;
  pcl_loader uut (.*);
  pcl_fuse_model fuse (.*);
  always #2 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    if (s !== e) err_total++;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) #1;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    rd = reg_rdata;
    er = reg_err;
  endtask
  task automatic pwr(input logic s);
    @(posedge clk);
    trial_mode_strap <= s;
    power_up_event <= 1'b1;
    @(posedge clk) #1;
    power_up_event <= 1'b0;
  endtask
  task automatic ld(input logic src);
    @(posedge clk);
    supply_above_uv <= 1'b0;
    config_source_strap <= src;
    dly <= 2'($random(seed));
    repeat (2) @(posedge clk);
    supply_above_uv <= 1'b1;
    for (int i = 0; i < 60 && load_done !== 1'b1; i++) @(posedge clk) #1;
  endtask
  task automatic fnchk();
    chk("serial", func_serial, exp_fn[0]);
    chk("ctrl_a", func_ctrl_a, exp_fn[1]);
    chk("ctrl_b", func_ctrl_b, exp_fn[2]);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 3; i++) words[i] = 8'($random(seed));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    ld(1'b0);
    exp_fn = words;
    fnchk();
    pwr(1'b0);
    chk("go", {7'h0, power_up_go}, 8'h01);
    chk("addr", {1'b0, target_addr}, {5'h01, words[0][2:0]});
    chk("crc_en", {7'h0, crc_en}, {7'h0, words[0][6]});
    trial_mode_strap <= 1'b1;
    in_quiescent_off <= 1'b1;
    burn_req <= 1'b1;
    acc(1'b1, 8'h77, 8'h01);
    acc(1'b0, 8'ha1, 8'h00);
    chk("mirror_1", rd, words[1]);
    v = 8'($random(seed));
    acc(1'b1, 8'ha2, v);
    acc(1'b0, 8'ha2, 8'h00);
    chk("mirror_2", rd, v);
    chk("limits", {crc_en, secure_wr_en, watchdog_disable,
                   target_addr[4:0]}, 8'h28);
    chk("off_entry", {7'h0, enter_quiescent_off}, 8'h01);
    chk("burn_en", {7'h0, fuse_burn_en}, 8'h01);
    acc(1'b1, 8'h77, 8'h00);
    for (int f = 0; f < 3; f++) begin
      self_test_done <= 1'b1;
      self_test_fail <= f != 1;
      @(posedge clk) #1;
      self_test_done <= 1'b0;
      acc(1'b0, 8'h7e, 8'h00);
      chk("stest", rd & 8'h04, {5'h0, f != 1, 2'h0});
    end
    trial_mode_strap <= 1'b0;
    low_power_off_default <= 1'b1;
    acc(1'b1, 8'h77, 8'h01);
    acc(1'b0, 8'ha0, 8'h00);
    chk("page_err", {7'h0, er}, 8'h01);
    acc(1'b1, 8'h77, 8'h00);
    acc(1'b1, 8'h7e, 8'h07);
    chk("flt_wr_err", {7'h0, er}, 8'h01);
    acc(1'b0, 8'h7e, 8'h00);
    chk("flt_kept", rd, 8'h04);
    pwr(1'b0);
    chk("go", {7'h0, power_up_go}, 8'h00);
    supply_above_uv <= 1'b0;
    trial_mode_strap <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("load_done", {7'h0, load_done}, 8'h00);
    acc(1'b1, 8'h77, 8'h01);
    acc(1'b0, 8'ha0, 8'h00);
    chk("wiped", rd, 8'h00);
    err_mask <= 3'h2;
    ld(1'b0);
    exp_fn[1] = 8'h00;
    fnchk();
    acc(1'b1, 8'h77, 8'h00);
    acc(1'b0, 8'h7e, 8'h00);
    chk("fuse_flt", rd, 8'h06);
    acc(1'b1, 8'h7e, 8'h07);
    acc(1'b0, 8'h7e, 8'h00);
    chk("flt_clr", rd, 8'h00);
    pwr(1'b1);
    chk("restr", {6'h0, power_up_go, restricted}, 8'h03);
    trial_mode_strap <= 1'b0;
    low_power_off_default <= 1'b0;
    ld(1'b1);
    exp_fn = '{8'h00, 8'h02, 8'h05};
    fnchk();
    trim_fail <= 1'b1;
    @(posedge clk) #1;
    trim_fail <= 1'b0;
    acc(1'b0, 8'h7e, 8'h00);
    chk("hw_flt", rd, 8'h01);
    pwr(1'b0);
    chk("go", {7'h0, power_up_go}, 8'h00);
    trial_mode_strap <= 1'b1;
    acc(1'b1, 8'h77, 8'h01);
    acc(1'b0, 8'ha0, 8'h00);
    chk("hw_page", {7'h0, er}, 8'h01);
    acc(1'b1, 8'h77, 8'h00);
    acc(1'b1, 8'h7e, 8'h00);
    acc(1'b0, 8'h7e, 8'h00);
    chk("hw_clr", rd, 8'h00);
    tally_and_finish();
  end
endmodule
